// ==== shared/dst_cfg.svh ====
// constants for the service diagnostic test selector
`ifndef DST_CFG_SVH
`define DST_CFG_SVH

// group switch codes and care masks (1 = closed)
`define DST_GRP_MASK      8'hfd
`define DST_GRP3_CODE     8'hd5
`define DST_GRP4_CODE     8'he5

// test switch codes and care masks
`define DST_T0_CODE       8'hff
`define DST_T0_MASK       8'hff
`define DST_T1_CODE       8'hfe
`define DST_T1_MASK       8'hff
`define DST_T2_CODE       8'hfc
`define DST_T2_MASK       8'hfe
`define DST_T3_CODE       8'hf8
`define DST_T3_MASK       8'hfc
`define DST_T4_CODE       8'hf0
`define DST_T4_MASK       8'hf8
`define DST_T5_CODE       8'he0
`define DST_T5_MASK       8'hf0
`define DST_T7_CODE       8'h80
`define DST_T7_MASK       8'hc0

// bus data patterns
`define DST_PAT_A         8'h55
`define DST_PAT_B         8'haa

// control line positions in the control vector
`define DST_SRQ           0
`define DST_EOI           1
`define DST_ATN           2
`define DST_IFC           3
`define DST_REN           4

// service acknowledge positions
`define DST_ACK_IO        0
`define DST_ACK_KBD       1
`define DST_ACK_BUS       2
`define DST_ACK_MSG       3
`define DST_ACK_RTC       4

// message bus own address, arbitrary value
`define DST_MSG_SELF      8'h1e

// timing
`define DST_CLK_HZ        50000000
`define DST_STEP_MS       250
`define DST_RTC_MS        8
`define DST_STEP_CYCLES   (`DST_STEP_MS * (`DST_CLK_HZ / 1000))
`define DST_RTC_CYCLES    (`DST_RTC_MS * (`DST_CLK_HZ / 1000))

`endif

// ==== shared/dst_pkg.sv ====
// types for the service diagnostic test selector
`default_nettype none
package dst_pkg;

	typedef enum logic [3:0] {
		T_NONE,
		T_BUS_DATA,
		T_BUS_CTRL,
		T_KBD_STAT,
		T_KBD_KEYS,
		T_PWR_SW,
		T_NMI,
		T_IO_TMR,
		T_KBD_IRQ,
		T_BUS_IRQ,
		T_MSG_LOOP,
		T_RTC
	} dst_test_type;

	typedef enum logic {
		NMI_LIT,
		NMI_DARK
	} dst_nmi_type;

endpackage : dst_pkg
`default_nettype wire

// ==== core/dst_tick_gen.sv ====
// periodic one-cycle tick while enabled
`timescale 1ns/10ps
`default_nettype none
module dst_tick_gen #(
	parameter int unsigned PERIOD = 4
) (
	// clock and reset
	input  wire logic mclk,
	input  wire logic rst,
	// control
	input  wire logic run,
	// result
	output var  logic tick
);
	localparam int unsigned W = $clog2(PERIOD + 1);

	logic [W-1:0] cnt;
	wire          last = (cnt == W'(PERIOD - 1));

	always_ff @(posedge mclk) begin
		if (rst || !run) begin
			cnt  <= '0;
			tick <= 1'b0;
		end else begin
			cnt  <= last ? '0 : cnt + W'(1);
			tick <= last;
		end
	end

endmodule : dst_tick_gen
`default_nettype wire

// ==== core/dst_selector.sv ====
// service diagnostic selector: switch decode and test sequencing
`timescale 1ns/10ps
`default_nettype none
`include "dst_cfg.svh"

module dst_selector
	import dst_pkg::*;
#(
	parameter int unsigned STEP_CYCLES = `DST_STEP_CYCLES,
	parameter int unsigned RTC_CYCLES  = `DST_RTC_CYCLES
) (
	// clock and reset
	input  wire logic       mclk,
	input  wire logic       rst,
	// service switches and preconditions
	input  wire logic [7:0] diag_group_switch,
	input  wire logic [7:0] diag_test_switch,
	input  wire logic       ram_ok,
	// instrument bus controller
	output var  logic       bus_ctrl_mode,
	output var  logic [7:0] bus_data_out,
	output var  logic       bus_data_oe,
	output var  logic [4:0] bus_ctl_out,
	output var  logic       bus_ctl_oe,
	output var  logic       bus_irq_force,
	input  wire logic       bus_irq,
	// keyboard link
	input  wire logic [7:0] kbd_selftest,
	input  wire logic [7:0] kbd_loop_status,
	input  wire logic [7:0] kbd_code,
	input  wire logic       kbd_code_valid,
	input  wire logic       kbd_nmi,
	input  wire logic       kbd_irq,
	output var  logic       kbd_irq_en,
	// i/o controller
	input  wire logic [7:0] io_read_status,
	input  wire logic       io_timer_irq,
	output var  logic       io_timer_en,
	// message bus
	input  wire logic       msg_irq,
	input  wire logic [7:0] msg_rx_data,
	output var  logic       msg_loop_en,
	output var  logic [7:0] msg_src_addr,
	output var  logic [7:0] msg_dst_addr,
	output var  logic       msg_send,
	output var  logic [7:0] msg_tx_data,
	// real-time clock
	input  wire logic [7:0] rtc_time,
	output var  logic       rtc_irq_en,
	output var  logic [7:0] rtc_period_ms,
	// service results
	output var  logic [4:0] irq_ack,
	output var  logic [7:0] leds
);

	////////////////////////////////////////////////////////////////////
	// switch decode

	dst_test_type next_sel;
	dst_test_type sel;
	dst_nmi_type  nmi_st;
	dst_nmi_type  next_nmi_st;
	logic [2:0]   phase;
	logic [7:0]   evt_cnt;
	logic [7:0]   key_hold;

	// masked compare ignores the X positions
	wire grp3 = ((diag_group_switch & `DST_GRP_MASK)
		== (`DST_GRP3_CODE & `DST_GRP_MASK));
	wire grp4 = ((diag_group_switch & `DST_GRP_MASK)
		== (`DST_GRP4_CODE & `DST_GRP_MASK));
	wire t0 = ((diag_test_switch & `DST_T0_MASK) == `DST_T0_CODE);
	wire t1 = ((diag_test_switch & `DST_T1_MASK) == `DST_T1_CODE);
	wire t2 = ((diag_test_switch & `DST_T2_MASK) == `DST_T2_CODE);
	wire t3 = ((diag_test_switch & `DST_T3_MASK) == `DST_T3_CODE);
	wire t4 = ((diag_test_switch & `DST_T4_MASK) == `DST_T4_CODE);
	wire t5 = ((diag_test_switch & `DST_T5_MASK) == `DST_T5_CODE);
	wire t7 = ((diag_test_switch & `DST_T7_MASK) == `DST_T7_CODE);
	wire g4_ok = grp4 && ram_ok;

	always_comb begin
		next_sel = T_NONE;
		if (grp3 && t0) begin
			next_sel = T_BUS_DATA;
		end else if (grp3 && t1) begin
			next_sel = T_BUS_CTRL;
		end else if (grp3 && t2) begin
			next_sel = T_KBD_STAT;
		end else if (grp3 && t3) begin
			next_sel = T_KBD_KEYS;
		end else if (grp3 && t4) begin
			next_sel = T_PWR_SW;
		end else if (g4_ok && t1) begin
			next_sel = T_NMI;
		end else if (g4_ok && t2) begin
			next_sel = T_IO_TMR;
		end else if (g4_ok && t3) begin
			next_sel = T_KBD_IRQ;
		end else if (g4_ok && t4) begin
			next_sel = T_BUS_IRQ;
		end else if (g4_ok && t5) begin
			next_sel = T_MSG_LOOP;
		end else if (g4_ok && t7) begin
			next_sel = T_RTC;
		end
	end

	////////////////////////////////////////////////////////////////////
	// step and rtc timing

	logic step_tick;
	logic rtc_tick;
	wire  steady   = (next_sel == sel);
	wire  step_run = steady && (sel != T_NONE);
	wire  rtc_run  = steady && (sel == T_RTC);

	dst_tick_gen #(
		.PERIOD (STEP_CYCLES)
	) u_step (
		.mclk (mclk),
		.rst  (rst),
		.run  (step_run),
		.tick (step_tick)
	);

	// stands in for the programmed 8 ms clock interrupt
	dst_tick_gen #(
		.PERIOD (RTC_CYCLES)
	) u_rtc (
		.mclk (mclk),
		.rst  (rst),
		.run  (rtc_run),
		.tick (rtc_tick)
	);

	////////////////////////////////////////////////////////////////////
	// per-test output values

	// control sequence: SRQ, EOI, EOI+ATN, ATN, ATN+IFC, IFC, REN, none
	logic [4:0] ctl_seq;
	always_comb begin
		ctl_seq = 5'h00;
		case (phase)
			3'd0: ctl_seq[`DST_SRQ] = 1'b1;
			3'd1: ctl_seq[`DST_EOI] = 1'b1;
			3'd2: begin
				ctl_seq[`DST_EOI] = 1'b1;
				ctl_seq[`DST_ATN] = 1'b1;
			end
			3'd3: ctl_seq[`DST_ATN] = 1'b1;
			3'd4: begin
				ctl_seq[`DST_ATN] = 1'b1;
				ctl_seq[`DST_IFC] = 1'b1;
			end
			3'd5: ctl_seq[`DST_IFC] = 1'b1;
			3'd6: ctl_seq[`DST_REN] = 1'b1;
			default: ctl_seq = 5'h00;
		endcase
	end

	wire is_bus   = (sel == T_BUS_DATA) || (sel == T_BUS_CTRL)
		|| (sel == T_BUS_IRQ);
	wire [7:0] pat = phase[0] ? `DST_PAT_B : `DST_PAT_A;
	wire [7:0] stat_pick = phase[0] ? kbd_loop_status : kbd_selftest;
	wire io_srv  = (sel == T_IO_TMR) && io_timer_irq;
	wire kbd_srv = (sel == T_KBD_IRQ) && (kbd_irq || kbd_code_valid);
	wire bus_srv = (sel == T_BUS_IRQ) && bus_irq;
	wire msg_srv = (sel == T_MSG_LOOP) && msg_irq;
	wire rtc_srv = (sel == T_RTC) && rtc_tick;
	wire key_in  = kbd_code_valid
		&& ((sel == T_KBD_KEYS) || (sel == T_KBD_IRQ));
	// a key from an earlier test must not show in a new one
	wire [7:0] next_key_hold = key_in ? kbd_code
		: (steady ? key_hold : 8'h00);

	always_comb begin
		next_nmi_st = nmi_st;
		case (nmi_st)
			NMI_LIT: begin
				if (sel == T_NMI && kbd_nmi) begin
					next_nmi_st = NMI_DARK;
				end
			end
			NMI_DARK: begin
				// a fresh NMI wins over the step that relights
				if (sel != T_NMI) begin
					next_nmi_st = NMI_LIT;
				end else if (step_tick && !kbd_nmi) begin
					next_nmi_st = NMI_LIT;
				end
			end
			default: next_nmi_st = NMI_LIT;
		endcase
	end

	logic [7:0] next_leds;
	always_comb begin
		next_leds = 8'h00;
		case (sel)
			T_BUS_DATA: next_leds = pat;
			T_BUS_CTRL: next_leds = {3'b000, ctl_seq};
			T_KBD_STAT: next_leds = stat_pick;
			T_KBD_KEYS: next_leds = key_in ? kbd_code : key_hold;
			T_PWR_SW:   next_leds = io_read_status;
			T_NMI:      next_leds = (next_nmi_st == NMI_DARK)
				? 8'h00 : 8'hff;
			T_IO_TMR:   next_leds = evt_cnt;
			T_KBD_IRQ:  next_leds = key_in ? kbd_code : key_hold;
			T_BUS_IRQ:  next_leds = {8{phase[0]}};
			T_MSG_LOOP: next_leds = msg_srv ? msg_rx_data : leds;
			T_RTC:      next_leds = rtc_srv ? rtc_time : leds;
			default:    next_leds = 8'h00;
		endcase
	end

	////////////////////////////////////////////////////////////////////
	// registers

	always_ff @(posedge mclk) begin
		if (rst) begin
			sel      <= T_NONE;
			nmi_st   <= NMI_LIT;
			phase    <= 3'd0;
			evt_cnt  <= 8'h00;
			key_hold <= 8'h00;
		end else begin
			sel      <= next_sel;
			nmi_st   <= next_nmi_st;
			phase    <= !steady ? 3'd0 : phase + 3'(step_tick);
			evt_cnt  <= !steady ? 8'h00 : evt_cnt + 8'(io_srv);
			key_hold <= next_key_hold;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			bus_ctrl_mode <= 1'b0;
			bus_data_out  <= 8'h00;
			bus_data_oe   <= 1'b0;
			bus_ctl_out   <= 5'h00;
			bus_ctl_oe    <= 1'b0;
			bus_irq_force <= 1'b0;
		end else begin
			bus_ctrl_mode <= is_bus;
			bus_data_oe   <= is_bus;
			bus_data_out  <= (sel == T_BUS_DATA) ? pat : 8'h00;
			bus_ctl_oe    <= is_bus;
			bus_ctl_out   <= (sel == T_BUS_CTRL) ? ctl_seq : 5'h00;
			bus_irq_force <= (sel == T_BUS_IRQ) && phase[0];
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			kbd_irq_en    <= 1'b0;
			io_timer_en   <= 1'b0;
			msg_loop_en   <= 1'b0;
			msg_src_addr  <= 8'h00;
			msg_dst_addr  <= 8'h00;
			msg_send      <= 1'b0;
			msg_tx_data   <= 8'h00;
			rtc_irq_en    <= 1'b0;
			rtc_period_ms <= 8'h00;
			irq_ack       <= 5'h00;
			leds          <= 8'h00;
		end else begin
			kbd_irq_en    <= (sel == T_KBD_IRQ);
			io_timer_en   <= (sel == T_IO_TMR);
			msg_loop_en   <= (sel == T_MSG_LOOP);
			msg_src_addr  <= `DST_MSG_SELF;
			msg_dst_addr  <= `DST_MSG_SELF;
			msg_send      <= (sel == T_MSG_LOOP) && step_tick;
			msg_tx_data   <= {5'h00, phase};
			rtc_irq_en    <= (sel == T_RTC);
			rtc_period_ms <= 8'(`DST_RTC_MS);
			irq_ack[`DST_ACK_IO]  <= io_srv;
			irq_ack[`DST_ACK_KBD] <= kbd_srv;
			irq_ack[`DST_ACK_BUS] <= bus_srv;
			irq_ack[`DST_ACK_MSG] <= msg_srv;
			irq_ack[`DST_ACK_RTC] <= rtc_srv;
			leds          <= next_leds;
		end
	end

	////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	wire g4_sel = (sel == T_NMI) || (sel == T_IO_TMR)
		|| (sel == T_KBD_IRQ) || (sel == T_BUS_IRQ)
		|| (sel == T_MSG_LOOP) || (sel == T_RTC);

	chk_group4_ram: assert property (
		g4_sel |-> $past(ram_ok))
		else $error("interrupt test ran without good RAM");

	chk_bus_pattern: assert property (
		(sel == T_BUS_DATA) && $past(sel) == T_BUS_DATA
		|-> bus_ctrl_mode && bus_data_oe
		&& (bus_data_out == `DST_PAT_A || bus_data_out == `DST_PAT_B))
		else $error("bus data pattern wrong");

	chk_ctrl_data_low: assert property (
		$past(sel) == T_BUS_CTRL
		|-> bus_data_out == 8'h00 && leds == {3'b000, bus_ctl_out})
		else $error("control test data lines not low");

	chk_pwr_status: assert property (
		$past(sel) == T_PWR_SW |-> leds == $past(io_read_status))
		else $error("status not shown on LEDs");

	chk_key_shown: assert property (
		(sel == T_KBD_KEYS && kbd_code_valid)
		|=> leds == $past(kbd_code))
		else $error("keycode not shown");

	chk_nmi_dark: assert property (
		(sel == T_NMI && kbd_nmi) |=> leds == 8'h00)
		else $error("LEDs not dark after NMI");

	chk_io_ack: assert property (
		(sel == T_IO_TMR && io_timer_irq)
		|=> irq_ack[`DST_ACK_IO] && io_timer_en)
		else $error("timer interrupt not serviced");

	chk_kbd_ack: assert property (
		(sel == T_KBD_IRQ && kbd_irq) |=> irq_ack[`DST_ACK_KBD])
		else $error("keyboard interrupt not serviced");

	chk_bus_flash: assert property (
		$past(sel) == T_BUS_IRQ |-> leds == {8{bus_irq_force}})
		else $error("LED flash not tied to irq line");

	chk_msg_self: assert property (
		msg_send |-> msg_loop_en && msg_src_addr == msg_dst_addr)
		else $error("loopback addresses differ");

	chk_rtc_time: assert property (
		(sel == T_RTC && rtc_tick)
		|=> leds == $past(rtc_time) && irq_ack[`DST_ACK_RTC])
		else $error("clock time not shown");

	chk_idle_quiet: assert property (
		(sel == T_NONE && $past(sel) == T_NONE)
		|-> leds == 8'h00 && !bus_ctrl_mode && irq_ack == 5'h00)
		else $error("idle selection not quiet");

	cov_ifc_atn: cover property (
		bus_ctl_out[`DST_IFC] && bus_ctl_out[`DST_ATN]);
	cov_nmi_cycle: cover property (
		sel == T_NMI && kbd_nmi ##1 leds == 8'h00 [*2] ##1 leds == 8'hff);
	cov_msg_loop: cover property (msg_send ##[1:20] irq_ack[`DST_ACK_MSG]);
	cov_rtc_tick: cover property (irq_ack[`DST_ACK_RTC]);

endmodule : dst_selector
`default_nettype wire

// ==== test/dst_far_model.sv ====
// far-side model: keyboard link, bus analyser and interrupt sources
`timescale 1ns/10ps
`default_nettype none
module dst_far_model (
	// clock
	input  wire logic       mclk,
	// from selector
	input  wire logic       bus_irq_force,
	input  wire logic       msg_send,
	input  wire logic [7:0] msg_tx_data,
	// to selector
	output var  logic       bus_irq,
	output var  logic [7:0] kbd_selftest,
	output var  logic [7:0] kbd_loop_status,
	output var  logic [7:0] kbd_code,
	output var  logic       kbd_code_valid,
	output var  logic       kbd_nmi,
	output var  logic       kbd_irq,
	output var  logic [7:0] io_read_status,
	output var  logic       io_timer_irq,
	output var  logic       msg_irq,
	output var  logic [7:0] msg_rx_data,
	output var  logic [7:0] rtc_time
);
	// analyser listens only, never drives data or control
	initial begin
		{io_timer_irq, kbd_irq, kbd_nmi, kbd_code_valid} = 4'h0;
		msg_irq = 1'b0;
		msg_rx_data = 8'h00;
		kbd_code = 8'h00;
		kbd_selftest = 8'h3c;
		kbd_loop_status = 8'hc3;
		io_read_status = 8'h81;
		rtc_time = 8'h42;
	end
	// interrupt line follows the forced level
	assign bus_irq = bus_irq_force;
	// loopback delivery one cycle later; released data inverted
	always @(posedge mclk) begin
		msg_irq <= msg_send;
		msg_rx_data <= msg_send ? msg_tx_data : ~msg_rx_data;
	end
	// one-cycle pulse on the chosen sources: {tmr,kirq,nmi,key}
	task automatic pulse(input logic [3:0] m, input logic [7:0] c);
		@(negedge mclk);
		kbd_code = c;
		{io_timer_irq, kbd_irq, kbd_nmi, kbd_code_valid} = m;
		@(negedge mclk);
		{io_timer_irq, kbd_irq, kbd_nmi, kbd_code_valid} = 4'h0;
		kbd_code = ~c;
	endtask : pulse
endmodule : dst_far_model
`default_nettype wire

// ==== test/dst_selector_tb.sv ====
// self-checking bench for the diagnostic test selector
`timescale 1ns/10ps
`default_nettype none
`include "dst_cfg.svh"
module dst_selector_tb;
	logic       mclk = 1'b0;
	logic       rst = 1'b1;
	logic [7:0] grp = 8'h00;
	logic [7:0] tst = 8'h00;
	logic       ram = 1'b0;
	logic       bus_ctrl_mode, bus_data_oe, bus_ctl_oe, bus_irq_force;
	logic       bus_irq, kbd_code_valid, kbd_nmi, kbd_irq, kbd_irq_en;
	logic       io_timer_irq, io_timer_en, msg_irq, msg_loop_en;
	logic       msg_send, rtc_irq_en;
	logic [7:0] bus_data_out, kbd_selftest, kbd_loop_status, kbd_code;
	logic [7:0] io_read_status, msg_rx_data, msg_src_addr, msg_dst_addr;
	logic [7:0] msg_tx_data, rtc_time, rtc_period_ms, leds, wa, wb, d0;
	logic [4:0] bus_ctl_out, irq_ack, acc_ack, acc_ctl;
	logic       ia, ea, ha, hb, f0, f1;
	int         n_mismatch = 0;
	int         samples_checked = 0;
	int         cyc = 0;
	int         gap;

	always #10 mclk = ~mclk;

	dst_selector #(.STEP_CYCLES(8), .RTC_CYCLES(5)) u_dut (
		.mclk(mclk), .rst(rst), .diag_group_switch(grp),
		.diag_test_switch(tst), .ram_ok(ram),
		.bus_ctrl_mode(bus_ctrl_mode), .bus_data_out(bus_data_out),
		.bus_data_oe(bus_data_oe), .bus_ctl_out(bus_ctl_out),
		.bus_ctl_oe(bus_ctl_oe), .bus_irq_force(bus_irq_force),
		.bus_irq(bus_irq), .kbd_selftest(kbd_selftest),
		.kbd_loop_status(kbd_loop_status), .kbd_code(kbd_code),
		.kbd_code_valid(kbd_code_valid), .kbd_nmi(kbd_nmi),
		.kbd_irq(kbd_irq), .kbd_irq_en(kbd_irq_en),
		.io_read_status(io_read_status), .io_timer_irq(io_timer_irq),
		.io_timer_en(io_timer_en), .msg_irq(msg_irq),
		.msg_rx_data(msg_rx_data), .msg_loop_en(msg_loop_en),
		.msg_src_addr(msg_src_addr), .msg_dst_addr(msg_dst_addr),
		.msg_send(msg_send), .msg_tx_data(msg_tx_data),
		.rtc_time(rtc_time), .rtc_irq_en(rtc_irq_en),
		.rtc_period_ms(rtc_period_ms), .irq_ack(irq_ack), .leds(leds)
	);

	dst_far_model u_far (
		.mclk(mclk), .bus_irq_force(bus_irq_force), .msg_send(msg_send),
		.msg_tx_data(msg_tx_data), .bus_irq(bus_irq),
		.kbd_selftest(kbd_selftest), .kbd_loop_status(kbd_loop_status),
		.kbd_code(kbd_code), .kbd_code_valid(kbd_code_valid),
		.kbd_nmi(kbd_nmi), .kbd_irq(kbd_irq),
		.io_read_status(io_read_status), .io_timer_irq(io_timer_irq),
		.msg_irq(msg_irq), .msg_rx_data(msg_rx_data), .rtc_time(rtc_time)
	);

	////////////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [7:0] s, e);
		samples_checked++;
		if (s !== e) begin
			n_mismatch++;
			$display("FAIL %s expected %h seen %h", nm, e, s);
		end
	endtask : chk

	task automatic conclude();
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : conclude

	// switch setting, then let selection and outputs settle
	task automatic sel(input logic [7:0] g, t, input logic r);
		@(negedge mclk);
		grp = g;
		tst = t;
		ram = r;
		repeat (3) @(negedge mclk);
	endtask : sel

	task automatic watch(input int n);
		{acc_ack, acc_ctl, ia, ea, ha, hb, f0, f1} = '0;
		repeat (n) begin
			acc_ack |= irq_ack;
			acc_ctl |= bus_ctl_out;
			ia |= bus_ctl_out[`DST_IFC] & bus_ctl_out[`DST_ATN];
			ea |= bus_ctl_out[`DST_EOI] & bus_ctl_out[`DST_ATN];
			ha |= (leds === wa);
			hb |= (leds === wb);
			f0 |= (bus_irq_force === 1'b0);
			f1 |= (bus_irq_force === 1'b1);
			@(negedge mclk);
		end
	endtask : watch

	task automatic rtc_gap();
		gap = 0;
		do begin
			@(negedge mclk);
			gap++;
		end while (irq_ack[`DST_ACK_RTC] !== 1'b1 && gap < 20);
	endtask : rtc_gap

	////////////////////////////////////////////////////////////////////////
	task automatic t_bus3();
		sel(8'hd5, 8'hff, 1'b0);
		d0 = bus_data_out;
		chk("ctrl_mode", bus_ctrl_mode, 8'h01);
		chk("data_oe", bus_data_oe, 8'h01);
		chk("pattern", (d0 === 8'h55 || d0 === 8'haa), 8'h01);
		repeat (8) @(negedge mclk);
		chk("alternate", bus_data_out, ~d0);
		sel(8'hd7, 8'hfe, 1'b0);
		watch(80);
		chk("ctl_lines", acc_ctl, 8'h1f);
		chk("ifc_atn", ia, 8'h01);
		chk("eoi_atn", ea, 8'h01);
		chk("ctl_data", bus_data_out, 8'h00);
		chk("ctl_oe", bus_ctl_oe, 8'h01);
		wa = 8'h3c;
		wb = 8'hc3;
		sel(8'hd5, 8'hfc, 1'b0);
		watch(40);
		chk("selftest", ha, 8'h01);
		chk("loopstat", hb, 8'h01);
		sel(8'hd5, 8'hf9, 1'b0);
		u_far.pulse(4'h1, 8'h5a);
		repeat (2) @(negedge mclk);
		chk("keycode", leds, 8'h5a);
		sel(8'hd5, 8'hf0, 1'b0);
		chk("pwr_sw", leds, 8'h81);
		sel(8'hd5, 8'he0, 1'b0);
		chk("undef_leds", leds, 8'h00);
		chk("undef_oe", {bus_data_oe, bus_ctl_oe}, 8'h00);
		sel(8'hd4, 8'hff, 1'b0);
		chk("grp_bit0", bus_data_oe, 8'h00);
	endtask : t_bus3

	task automatic t_ram_low();
		sel(8'he5, 8'hfd, 1'b0);
		chk("ram_low_en", io_timer_en, 8'h00);
		u_far.pulse(4'h8, 8'h00);
		watch(4);
		chk("ram_low_ack", acc_ack, 8'h00);
	endtask : t_ram_low

	task automatic t_irq4();
		sel(8'he7, 8'hfe, 1'b1);
		u_far.pulse(4'h2, 8'h00);
		@(negedge mclk);
		chk("nmi_off", leds, 8'h00);
		wa = 8'hff;
		watch(12);
		chk("nmi_on", ha, 8'h01);
		sel(8'he5, 8'hfd, 1'b1);
		chk("tmr_en", io_timer_en, 8'h01);
		u_far.pulse(4'h8, 8'h00);
		watch(3);
		chk("tmr_ack", acc_ack, 8'h01);
		chk("tmr_leds", leds, 8'h01);
		sel(8'he5, 8'hf9, 1'b1);
		chk("kbd_en", kbd_irq_en, 8'h01);
		chk("key_clear", leds, 8'h00);
		u_far.pulse(4'h1, 8'h96);
		watch(3);
		chk("key_ack", acc_ack, 8'h02);
		chk("key_leds", leds, 8'h96);
		u_far.pulse(4'h4, 8'h00);
		watch(3);
		chk("kirq_ack", acc_ack, 8'h02);
		sel(8'he5, 8'hf7, 1'b1);
		watch(40);
		chk("force_cycle", {f1, f0}, 8'h03);
		chk("bus_ack", acc_ack[`DST_ACK_BUS], 8'h01);
		sel(8'he5, 8'hef, 1'b1);
		chk("loop_en", msg_loop_en, 8'h01);
		chk("src", msg_src_addr, `DST_MSG_SELF);
		chk("dst", msg_dst_addr, `DST_MSG_SELF);
		watch(20);
		chk("msg_ack", acc_ack, 8'h08);
		sel(8'he5, 8'hbf, 1'b1);
		chk("rtc_ms", rtc_period_ms, 8'h08);
		chk("rtc_en", rtc_irq_en, 8'h01);
		rtc_gap();
		rtc_gap();
		chk("rtc_gap", gap[7:0], 8'h05);
		@(negedge mclk);
		chk("rtc_leds", leds, 8'h42);
	endtask : t_irq4

	// reset in mid-run: outputs off, then back two edges after release
	task automatic t_reset();
		sel(8'hd5, 8'hff, 1'b0);
		rst = 1'b1;
		repeat (2) @(negedge mclk);
		chk("rst_oe", bus_data_oe, 8'h00);
		chk("rst_leds", leds, 8'h00);
		rst = 1'b0;
		@(negedge mclk);
		chk("rel_oe1", bus_data_oe, 8'h00);
		@(negedge mclk);
		chk("rel_oe2", bus_data_oe, 8'h01);
	endtask : t_reset

	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc >= 3000) begin
			n_mismatch++;
			conclude();
		end
	end

	initial begin
		repeat (20) @(negedge mclk);
		chk("reset_leds", leds, 8'h00);
		rst = 1'b0;
		t_bus3();
		t_ram_low();
		t_irq4();
		t_reset();
		conclude();
	end
endmodule : dst_selector_tb
`default_nettype wire
